// ==== hw/cpa_config_port.sv ====
// Configuration port front end: key entry, index/data pair, global
// registers, base relocation and serial-port activate bits.
// Assumes host I/O strobes are one-cycle pulses synchronous to clk_i.
`timescale 1ns/1ps
`include "cpa_consts.svh"

module cpa_config_port
    import cpa_pkg::*;
#(
    parameter int unsigned BLOCK_CYCLES =
        `CPA_BLOCK_TIME_US * `CPA_CLK_MHZ
) (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        host_bus_reset_n_i,
    input  wire logic        base_low_strap_pin_i,
    input  wire logic        base_high_strap_pin_i,
    input  wire logic        io_wr_i,
    input  wire logic        io_rd_i,
    input  wire logic [15:0] io_addr_i,
    input  wire logic [7:0]  io_wdata_i,
    output logic      [7:0]  io_rdata_o,
    output logic             io_rd_ack_o,
    output logic             cfg_mode_o,
    output logic      [15:0] cfg_base_o,
    output logic      [1:0]  ser_active_o,
    output logic             host_blocked_o
);

    function automatic logic port_hit(input logic [15:0] a,
                                      input logic [15:0] b,
                                      input logic        data_port);
        port_hit = (a == (b + {15'h0000, data_port}));
    endfunction

    logic            hard_rst;
    logic            rst_prev_q;
    logic            rst_prev_d;
    logic            strap_lo_q, strap_lo_d;
    logic            strap_hi_q, strap_hi_d;
    logic            strap_vld_q, strap_vld_d;
    logic            host_blk_q, host_blk_d;
    logic [16:0]     blk_cnt_q, blk_cnt_d;
    cpa_mode_e       mode_q, mode_d;
    cpa_byte_t       index_q, index_d;
    cpa_byte_t       ldn_q, ldn_d;
    cpa_byte_t       base_lo_pend_q, base_lo_pend_d;
    logic [15:0]     base_q, base_d;
    logic [1:0]      act_q, act_d;
    cpa_byte_t       rdata_q, rdata_d;
    logic            rd_ack_q, rd_ack_d;
    logic            cfg_q, cfg_d;
    logic            blocked;
    logic            in_cfg;
    logic            wr_idx, wr_dat, rd_idx, rd_dat;
    cpa_byte_t       reg_rd;

    // Host bus reset and power-on reset both restore the strap address
    assign hard_rst = reset_i | ~host_bus_reset_n_i;

    // Straps are caught on the first cycle after any hard reset releases
    always_comb begin
        rst_prev_d  = hard_rst;
        strap_lo_d  = strap_lo_q;
        strap_hi_d  = strap_hi_q;
        strap_vld_d = strap_vld_q;
        if (rst_prev_q && !hard_rst) begin
            strap_lo_d  = base_low_strap_pin_i;
            strap_hi_d  = base_high_strap_pin_i;
            strap_vld_d = 1'b1;
        end
        // Registered so the blocked output comes straight from a flop
        host_blk_d = (blk_cnt_d != 17'h00000) || !strap_vld_d;
    end

    always_ff @(posedge clk_i) begin
        rst_prev_q <= rst_prev_d;
        if (hard_rst) begin
            strap_lo_q  <= 1'b0;
            strap_hi_q  <= 1'b0;
            strap_vld_q <= 1'b0;
            host_blk_q  <= 1'b1;
        end else begin
            strap_lo_q  <= strap_lo_d;
            strap_hi_q  <= strap_hi_d;
            strap_vld_q <= strap_vld_d;
            host_blk_q  <= host_blk_d;
        end
    end

    // Blocking window only follows the supply power-on reset
    always_comb begin
        blk_cnt_d = blk_cnt_q;
        if (blk_cnt_q != 17'h00000) begin
            blk_cnt_d = blk_cnt_q - 17'h00001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            blk_cnt_q <= BLOCK_CYCLES[16:0];
        end else begin
            blk_cnt_q <= blk_cnt_d;
        end
    end

    // Accesses also wait for the strap sample so the base is defined
    assign blocked = host_blk_q;
    assign in_cfg  = (mode_q == CPA_CFG);
    assign wr_idx  = io_wr_i && !blocked &&
                     port_hit(io_addr_i, base_q, 1'b0);
    assign wr_dat  = io_wr_i && !blocked && in_cfg &&
                     port_hit(io_addr_i, base_q, 1'b1);
    assign rd_idx  = io_rd_i && !blocked && in_cfg &&
                     port_hit(io_addr_i, base_q, 1'b0);
    assign rd_dat  = io_rd_i && !blocked && in_cfg &&
                     port_hit(io_addr_i, base_q, 1'b1);

    // Full eight-bit index decode; everything else reads as zero
    always_comb begin
        reg_rd = 8'h00;
        case (index_q)
            `CPA_IDX_LDN:     reg_rd = ldn_q;
            `CPA_IDX_BASE_LO: reg_rd = base_q[7:0];
            `CPA_IDX_BASE_HI: reg_rd = base_q[15:8];
            `CPA_IDX_ACTIVATE: begin
                if (ldn_q == `CPA_LDN_SER1) begin
                    reg_rd = {7'h00, act_q[0]};
                end else if (ldn_q == `CPA_LDN_SER2) begin
                    reg_rd = {7'h00, act_q[1]};
                end
            end
            default: reg_rd = 8'h00;
        endcase
    end

    always_comb begin
        mode_d         = mode_q;
        index_d        = index_q;
        ldn_d          = ldn_q;
        base_lo_pend_d = base_lo_pend_q;
        base_d         = base_q;
        act_d          = act_q;
        rdata_d        = 8'h00;
        rd_ack_d       = 1'b0;
        if (rst_prev_q && !hard_rst) begin
            base_d = {base_high_strap_pin_i ? `CPA_BASE_HI_STRAP1
                                            : `CPA_BASE_HI_STRAP0,
                      base_low_strap_pin_i  ? `CPA_BASE_LO_STRAP1
                                            : `CPA_BASE_LO_STRAP0};
        end
        case (mode_q)
            CPA_RUN: begin
                // Only the enter key matters here; all else is dropped
                if (wr_idx && io_wdata_i == `CPA_KEY_ENTER) begin
                    mode_d = CPA_CFG;
                end
            end
            CPA_CFG: begin
                if (wr_idx) begin
                    if (io_wdata_i == `CPA_KEY_EXIT) begin
                        mode_d = CPA_RUN;
                    end else begin
                        index_d = io_wdata_i;
                    end
                end
                if (wr_dat) begin
                    case (index_q)
                        `CPA_IDX_CFG_CTRL: begin
                            if (io_wdata_i[`CPA_SOFT_RST_BIT]) begin
                                // Soft reset leaves base and mode alone
                                index_d = 8'h00;
                                ldn_d   = `CPA_LDN_RESET;
                                act_d   = 2'b00;
                            end
                        end
                        `CPA_IDX_LDN:     ldn_d = io_wdata_i;
                        `CPA_IDX_BASE_LO: base_lo_pend_d = io_wdata_i;
                        `CPA_IDX_BASE_HI: begin
                            // Move takes effect on the high byte write
                            base_d = {io_wdata_i,
                                      base_lo_pend_q[7:1], 1'b0};
                        end
                        `CPA_IDX_ACTIVATE: begin
                            if (ldn_q == `CPA_LDN_SER1) begin
                                act_d[0] = io_wdata_i[`CPA_ACT_BIT];
                            end else if (ldn_q == `CPA_LDN_SER2) begin
                                act_d[1] = io_wdata_i[`CPA_ACT_BIT];
                            end
                        end
                        default: ;
                    endcase
                end
                if (rd_idx) begin
                    rdata_d  = index_q;
                    rd_ack_d = 1'b1;
                end else if (rd_dat) begin
                    rdata_d  = reg_rd;
                    rd_ack_d = 1'b1;
                end
            end
            default: mode_d = CPA_RUN;
        endcase
        cfg_d = (mode_d == CPA_CFG);
    end

    always_ff @(posedge clk_i) begin
        if (hard_rst) begin
            mode_q         <= CPA_RUN;
            cfg_q          <= 1'b0;
            index_q        <= 8'h00;
            ldn_q          <= `CPA_LDN_RESET;
            base_lo_pend_q <= 8'h00;
            base_q         <= 16'h0000;
            act_q          <= 2'b00;
            rdata_q        <= 8'h00;
            rd_ack_q       <= 1'b0;
        end else begin
            mode_q         <= mode_d;
            cfg_q          <= cfg_d;
            index_q        <= index_d;
            ldn_q          <= ldn_d;
            base_lo_pend_q <= base_lo_pend_d;
            base_q         <= base_d;
            act_q          <= act_d;
            rdata_q        <= rdata_d;
            rd_ack_q       <= rd_ack_d;
        end
    end

    assign io_rdata_o     = rdata_q;
    assign io_rd_ack_o    = rd_ack_q;
    assign cfg_mode_o     = cfg_q;
    assign cfg_base_o     = base_q;
    assign ser_active_o   = act_q;
    assign host_blocked_o = host_blk_q;

    sequence s_enter_write;
        !in_cfg && io_wr_i && !blocked && io_addr_i == base_q &&
        io_wdata_i == `CPA_KEY_ENTER;
    endsequence

    sequence s_exit_write;
        in_cfg && io_wr_i && !blocked && io_addr_i == base_q &&
        io_wdata_i == `CPA_KEY_EXIT;
    endsequence

    a_enter_key: assert property (
        @(posedge clk_i) disable iff (hard_rst)
        s_enter_write |=> cfg_mode_o)
        else $error("enter key did not reach configuration state");

    a_exit_key: assert property (
        @(posedge clk_i) disable iff (hard_rst)
        s_exit_write |=> !cfg_mode_o)
        else $error("exit key did not return to run state");

    a_run_ignore: assert property (
        @(posedge clk_i) disable iff (hard_rst)
        !in_cfg && !(io_wr_i && io_wdata_i == `CPA_KEY_ENTER)
        |=> !cfg_mode_o && $stable(index_q))
        else $error("run state changed without enter key");

    a_run_no_read: assert property (
        @(posedge clk_i) disable iff (hard_rst)
        !in_cfg |=> !io_rd_ack_o)
        else $error("read answered outside configuration state");

    a_reset_state: assert property (
        @(posedge clk_i)
        hard_rst |=> !cfg_mode_o && ser_active_o == 2'b00)
        else $error("reset left a device active or config mode");

    a_strap_base: assert property (
        @(posedge clk_i) disable iff (hard_rst)
        rst_prev_q && !hard_rst |=> cfg_base_o == {
            $past(base_high_strap_pin_i) ? `CPA_BASE_HI_STRAP1
                                         : `CPA_BASE_HI_STRAP0,
            $past(base_low_strap_pin_i)  ? `CPA_BASE_LO_STRAP1
                                         : `CPA_BASE_LO_STRAP0})
        else $error("strap base address wrong after reset");

    a_strap_hold: assert property (
        @(posedge clk_i) disable iff (hard_rst)
        strap_vld_q |=> $stable(strap_lo_q) && $stable(strap_hi_q))
        else $error("strap sample changed without reset");

    a_block_power: assert property (
        @(posedge clk_i) disable iff (hard_rst)
        host_blocked_o && io_wr_i |=> !cfg_mode_o || $past(in_cfg))
        else $error("access accepted while blocked");

    a_base_move: assert property (
        @(posedge clk_i) disable iff (hard_rst)
        wr_dat && index_q == `CPA_IDX_BASE_HI
        |=> cfg_base_o == {$past(io_wdata_i),
                           $past(base_lo_pend_q[7:1]), 1'b0})
        else $error("base did not move on high byte write");

    a_soft_reset: assert property (
        @(posedge clk_i) disable iff (hard_rst)
        wr_dat && index_q == `CPA_IDX_CFG_CTRL && io_wdata_i[0]
        |=> ser_active_o == 2'b00 && ldn_q == `CPA_LDN_RESET)
        else $error("soft reset did not clear configuration");

endmodule

// ==== hw/cpa_consts.svh ====
// Constants for the configuration port front end.
// Assumes inclusion by the design module and the bench only.
`ifndef CPA_CONSTS_SVH
`define CPA_CONSTS_SVH

`define CPA_KEY_ENTER       8'h55
`define CPA_KEY_EXIT        8'haa
`define CPA_BASE_LO_STRAP0  8'h2e
`define CPA_BASE_LO_STRAP1  8'h4e
`define CPA_BASE_HI_STRAP0  8'h16
`define CPA_BASE_HI_STRAP1  8'h00
`define CPA_IDX_CFG_CTRL    8'h02
`define CPA_IDX_LDN         8'h07
`define CPA_IDX_BASE_LO     8'h26
`define CPA_IDX_BASE_HI     8'h27
`define CPA_IDX_GLOBAL_LAST 8'h2f
`define CPA_IDX_ACTIVATE    8'h30
`define CPA_LDN_SER1        8'h04
`define CPA_LDN_SER2        8'h05
`define CPA_SOFT_RST_BIT    0
`define CPA_ACT_BIT         0
`define CPA_LDN_RESET       8'h00
`define CPA_BLOCK_TIME_US   500
`define CPA_CLK_MHZ         250

`endif

// ==== hw/cpa_pkg.sv ====
// Types shared by the configuration port front end.
// Assumes the constants header is on the include path.
package cpa_pkg;
    typedef enum logic {
        CPA_RUN,
        CPA_CFG
    } cpa_mode_e;
    typedef logic [7:0] cpa_byte_t;
endpackage

// ==== tb/cpa_host_model.sv ====
// Host model: one-cycle I/O write and read strobes, index/data pairs.
// Assumes the bench calls one task at a time, after a clock edge.
`timescale 1ns/1ps

module cpa_host_model (
    input  wire logic        clk_i,
    input  wire logic [7:0]  io_rdata_i,
    input  wire logic        io_rd_ack_i,
    output logic             io_wr_o,
    output logic             io_rd_o,
    output logic      [15:0] io_addr_o,
    output logic      [7:0]  io_wdata_o
);
    initial begin
        io_wr_o    = 1'b0;
        io_rd_o    = 1'b0;
        io_addr_o  = 16'h0000;
        io_wdata_o = 8'h00;
    end

    // Released lines show inverted values so a stale match cannot pass
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        io_wr_o    <= 1'b1;
        io_addr_o  <= a;
        io_wdata_o <= d;
        @(posedge clk_i);
        io_wr_o    <= 1'b0;
        io_addr_o  <= ~a;
        io_wdata_o <= ~d;
        #1;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d,
                      output logic ack);
        @(posedge clk_i);
        io_rd_o   <= 1'b1;
        io_addr_o <= a;
        @(posedge clk_i);
        io_rd_o   <= 1'b0;
        io_addr_o <= ~a;
        #1;
        ack = io_rd_ack_i;
        d   = io_rdata_i;
    endtask

    // Index first, then the data port one above the base
    task automatic reg_wr(input logic [15:0] b, input logic [7:0] i,
                          input logic [7:0] d);
        wr(b, i);
        wr(b + 16'h0001, d);
    endtask

    task automatic reg_rd(input logic [15:0] b, input logic [7:0] i,
                          output logic [7:0] d, output logic ack);
        wr(b, i);
        rd(b + 16'h0001, d, ack);
    endtask
endmodule

// ==== tb/cpa_config_port_tb.sv ====
// Self-checking bench for the configuration port front end.
// Assumes the host model and the constants header are available.
`timescale 1ns/1ps
`include "cpa_consts.svh"

module cpa_config_port_tb
    import cpa_pkg::*;
;
    localparam int unsigned BLK = 20;
    logic        clk_i;
    logic        reset_i;
    logic        host_bus_reset_n_i;
    logic        lo_pin;
    logic        hi_pin;
    logic        io_wr;
    logic        io_rd;
    logic [15:0] io_addr;
    logic [7:0]  io_wdata;
    logic [7:0]  io_rdata;
    logic        io_rd_ack;
    logic        cfg_mode;
    logic [15:0] cfg_base;
    logic [1:0]  ser_active;
    logic        host_blocked;
    int          err_total;
    int          compares;
    int          seed;
    logic [15:0] base;
    logic [15:0] nb;
    logic [7:0]  d;
    logic [7:0]  lo;
    logic [7:0]  hi;
    logic        ack;

    cpa_config_port #(.BLOCK_CYCLES(BLK)) dut (
        .clk_i                 (clk_i),
        .reset_i               (reset_i),
        .host_bus_reset_n_i    (host_bus_reset_n_i),
        .base_low_strap_pin_i  (lo_pin),
        .base_high_strap_pin_i (hi_pin),
        .io_wr_i               (io_wr),
        .io_rd_i               (io_rd),
        .io_addr_i             (io_addr),
        .io_wdata_i            (io_wdata),
        .io_rdata_o            (io_rdata),
        .io_rd_ack_o           (io_rd_ack),
        .cfg_mode_o            (cfg_mode),
        .cfg_base_o            (cfg_base),
        .ser_active_o          (ser_active),
        .host_blocked_o        (host_blocked)
    );

    cpa_host_model host (
        .clk_i       (clk_i),
        .io_rdata_i  (io_rdata),
        .io_rd_ack_i (io_rd_ack),
        .io_wr_o     (io_wr),
        .io_rd_o     (io_rd),
        .io_addr_o   (io_addr),
        .io_wdata_o  (io_wdata)
    );

    function automatic logic [15:0] exp_base(input logic h, input logic l);
        exp_base = {h ? `CPA_BASE_HI_STRAP1 : `CPA_BASE_HI_STRAP0,
                    l ? `CPA_BASE_LO_STRAP1 : `CPA_BASE_LO_STRAP0};
    endfunction

    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("counts: compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic wait_free();
        int n;
        n = 0;
        while (host_blocked !== 1'b0 && n < 200) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (n >= 200) begin
            err_total++;
            $display("BAD host_blocked expected 0 seen 1");
            give_verdict();
        end
    endtask

    // Straps must stay latched while the pins move afterwards
    task automatic bus_reset();
        @(posedge clk_i);
        host_bus_reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        host_bus_reset_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        lo_pin <= ~lo_pin;
        hi_pin <= ~hi_pin;
        wait_free();
    endtask

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    initial begin
        reset_i            = 1'b1;
        host_bus_reset_n_i = 1'b1;
        lo_pin             = 1'b0;
        hi_pin             = 1'b0;
        err_total          = 0;
        compares           = 0;
        seed               = 32'hc3cb;
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        host.wr(exp_base(1'b0, 1'b0), `CPA_KEY_ENTER);
        chk("blocked", host_blocked, 16'h1);
        chk("mode_blk", cfg_mode, 16'h0);
        wait_free();
        chk("base_por", cfg_base, exp_base(1'b0, 1'b0));
        $display("test power-on block done");
        for (int s = 0; s < 4; s++) begin
            @(posedge clk_i);
            {hi_pin, lo_pin} <= s[1:0];
            bus_reset();
            base = exp_base(s[1], s[0]);
            chk("base_strap", cfg_base, base);
            chk("mode_rst", cfg_mode, 16'h0);
            chk("ser_rst", {14'h0, ser_active}, 16'h0);
        end
        $display("test straps done");
        for (int i = 0; i < 6; i++) begin
            d = 8'($random(seed));
            if (d == `CPA_KEY_ENTER) d = 8'h00;
            host.wr(base, d);
        end
        chk("mode_run", cfg_mode, 16'h0);
        host.rd(base + 16'h0001, d, ack);
        chk("ack_run", ack, 16'h0);
        host.wr(base, `CPA_KEY_ENTER);
        chk("mode_enter", cfg_mode, 16'h1);
        host.rd(base + 16'h0002, d, ack);
        chk("ack_unmapped", ack, 16'h0);
        // Only the two serial port devices are ever selected
        for (int i = 4; i < 6; i++) begin
            host.reg_wr(base, `CPA_IDX_LDN, 8'(i));
            host.reg_wr(base, `CPA_IDX_ACTIVATE, 8'h01);
            host.reg_rd(base, `CPA_IDX_ACTIVATE, d, ack);
            chk("act_rd", {7'h0, ack, d}, 16'h0101);
        end
        chk("ser_on", {14'h0, ser_active}, 16'h3);
        host.reg_rd(base, `CPA_IDX_LDN, d, ack);
        chk("ldn_rd", {7'h0, ack, d}, {8'h01, `CPA_LDN_SER2});
        d = 8'h08 + (8'($random(seed)) & 8'h0f);
        host.reg_wr(base, d, 8'($random(seed)));
        host.reg_rd(base, d, d, ack);
        chk("unimpl_rd", {7'h0, ack, d}, 16'h0100);
        host.reg_wr(base, `CPA_IDX_CFG_CTRL, 8'h01);
        chk("ser_soft", {14'h0, ser_active}, 16'h0);
        chk("mode_soft", cfg_mode, 16'h1);
        $display("test device select done");
        lo = 8'($random(seed)) | 8'h01;
        hi = 8'h20 + (8'($random(seed)) & 8'h3f);
        host.reg_wr(base, `CPA_IDX_BASE_LO, lo);
        chk("base_pend", cfg_base, base);
        host.reg_wr(base, `CPA_IDX_BASE_HI, hi);
        nb = {hi, lo & 8'hfe};
        chk("base_move", cfg_base, nb);
        host.reg_rd(nb, `CPA_IDX_BASE_LO, d, ack);
        chk("base_lo_rd", {7'h0, ack, d}, {8'h01, lo & 8'hfe});
        host.rd(nb, d, ack);
        chk("idx_rd", {7'h0, ack, d}, {8'h01, `CPA_IDX_BASE_LO});
        host.rd(base + 16'h0001, d, ack);
        chk("old_base", ack, 16'h0);
        host.wr(nb, `CPA_KEY_EXIT);
        chk("mode_exit", cfg_mode, 16'h0);
        host.wr(nb, `CPA_KEY_ENTER);
        chk("mode_again", cfg_mode, 16'h1);
        // Pins back to the straps that chose the original base
        @(posedge clk_i);
        {hi_pin, lo_pin} <= 2'b11;
        bus_reset();
        chk("base_back", cfg_base, base);
        chk("mode_back", cfg_mode, 16'h0);
        $display("test relocation done");
        give_verdict();
    end
endmodule
